// [logic/adj_pkg.sv]
// package: constants and carrier types for the conversion-done interrupt block
package adj_pkg;
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned RES_W = 10;
   localparam int unsigned PAIR_W = 16;
   localparam int unsigned PAD_W = PAIR_W - RES_W;

   localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_ENABLE = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_CLEAR = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_CONTROL = 8'h0C;
   localparam logic [ADDR_W-1:0] OFS_RESULT = 8'h10;

   localparam int unsigned BIT_DONE = 0;
   localparam int unsigned BIT_JUSTIFY = 0;
   localparam int unsigned BIT_GLOBAL = 1;
   localparam int unsigned BIT_PERIPH = 2;
   localparam int unsigned BIT_CLKSRC = 3;

   localparam logic RST_FLAG = 1'b0;
   localparam logic RST_ENABLE = 1'b0;
   localparam logic [3:0] RST_CONTROL = 4'h0;
   localparam logic [RES_W-1:0] RST_RESULT = 10'h000;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [3:0] {
      ADJ_ST_RUN = 4'h1,
      ADJ_ST_SLEEP = 4'h2,
      ADJ_ST_NEXT = 4'h4,
      ADJ_ST_BRANCH = 4'h8
   } adj_wake_e;

   typedef struct packed {
      logic sleep_enter;
      logic instr_done;
   } adj_core_in_s;

   typedef struct packed {
      logic irq;
      logic asleep;
      logic wake;
      logic exec_next;
      logic vector;
      logic resume;
   } adj_core_out_s;

   typedef struct packed {
      logic done;
      logic [RES_W-1:0] result;
   } adj_conv_s;
endpackage : adj_pkg

// [logic/adj_format.sv]
// module: registered left or right justification of the conversion result
`timescale 1ns/10ps
`default_nettype none
module adj_format (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic justify_left,
   input wire logic [adj_pkg::RES_W-1:0] raw,
   output logic [adj_pkg::PAIR_W-1:0] pair
);
   logic [adj_pkg::PAIR_W-1:0] pair_ff;
   logic [adj_pkg::PAIR_W-1:0] nxt_pair;

   always_comb begin
      if (justify_left) begin
         nxt_pair = {raw, {adj_pkg::PAD_W{1'b0}}};
      end else begin
         nxt_pair = {{adj_pkg::PAD_W{1'b0}}, raw};
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         pair_ff <= '0;
      end else begin
         pair_ff <= nxt_pair;
      end
   end

   assign pair = pair_ff;

   just_left_a: assert property (@(posedge clk) disable iff (!rst_b)
      justify_left |=> pair_ff == {$past(raw), 6'h00})
      else $error("left justified pair wrong");
   just_right_a: assert property (@(posedge clk) disable iff (!rst_b)
      !justify_left |=> pair_ff == {6'h00, $past(raw)})
      else $error("right justified pair wrong");
endmodule : adj_format
`default_nettype wire

// [logic/adj_wake.sv]
// module: sleep and wake sequencing toward the core
`timescale 1ns/10ps
`default_nettype none
module adj_wake (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic irq,
   input wire logic global_irq_enable,
   input wire logic peripheral_irq_enable,
   input wire adj_pkg::adj_core_in_s core_in,
   output logic asleep,
   output logic wake,
   output logic exec_next,
   output logic vector,
   output logic resume
);
   adj_pkg::adj_wake_e state_ff;
   adj_pkg::adj_wake_e nxt_state;
   logic wake_ff;
   logic vector_ff;
   logic resume_ff;

   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         adj_pkg::ADJ_ST_RUN: begin
            if (core_in.sleep_enter) begin
               nxt_state = adj_pkg::ADJ_ST_SLEEP;
            end
         end
         adj_pkg::ADJ_ST_SLEEP: begin
            if (irq) begin
               nxt_state = adj_pkg::ADJ_ST_NEXT;
            end
         end
         adj_pkg::ADJ_ST_NEXT: begin
            if (core_in.instr_done) begin
               nxt_state = adj_pkg::ADJ_ST_BRANCH;
            end
         end
         adj_pkg::ADJ_ST_BRANCH: begin
            nxt_state = adj_pkg::ADJ_ST_RUN;
         end
         default: begin
            nxt_state = adj_pkg::ADJ_ST_RUN;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         state_ff <= adj_pkg::ADJ_ST_RUN;
      end else begin
         state_ff <= nxt_state;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         wake_ff <= 1'b0;
         vector_ff <= 1'b0;
         resume_ff <= 1'b0;
      end else begin
         wake_ff <= (state_ff == adj_pkg::ADJ_ST_SLEEP) && irq;
         vector_ff <= (state_ff == adj_pkg::ADJ_ST_BRANCH) && global_irq_enable && peripheral_irq_enable;
         resume_ff <= (state_ff == adj_pkg::ADJ_ST_BRANCH) && !(global_irq_enable && peripheral_irq_enable);
      end
   end

   assign asleep = (state_ff == adj_pkg::ADJ_ST_SLEEP);
   assign exec_next = (state_ff == adj_pkg::ADJ_ST_NEXT);
   assign wake = wake_ff;
   assign vector = vector_ff;
   assign resume = resume_ff;

   sequence wake_seen_s;
      (state_ff == adj_pkg::ADJ_ST_SLEEP) && irq;
   endsequence
   sequence next_done_s;
      (state_ff == adj_pkg::ADJ_ST_NEXT) && core_in.instr_done;
   endsequence

   wake_on_irq_a: assert property (@(posedge clk) disable iff (!rst_b)
      wake_seen_s |=> wake_ff && exec_next)
      else $error("irq in sleep did not wake");
   next_before_vector_a: assert property (@(posedge clk) disable iff (!rst_b)
      vector_ff |-> $past(state_ff, 2) == adj_pkg::ADJ_ST_NEXT)
      else $error("vector without prior next instruction");
   branch_isr_a: assert property (@(posedge clk) disable iff (!rst_b)
      next_done_s ##1 (global_irq_enable && peripheral_irq_enable) |=> vector_ff && !resume_ff)
      else $error("enabled wake did not vector");
   resume_inline_a: assert property (@(posedge clk) disable iff (!rst_b)
      next_done_s ##1 !(global_irq_enable && peripheral_irq_enable) |=> resume_ff && !vector_ff)
      else $error("disabled wake did not resume");
endmodule : adj_wake
`default_nettype wire

// [logic/adj_top.sv]
// module: conversion-done flag, interrupt gating, result format and register slave
//
// Summary of operation
// - flag sets at every accepted conversion end, enable or not
// - interrupt to core only when flag and enable are both set
// - conversions proceed in sleep only with the rc clock source selected
// - interrupt may fire running or asleep; enabled interrupt wakes from sleep
// - after wake the instruction after sleep runs before any vectoring
// - after wake vector if global and peripheral enables set, else resume inline
// - result shown left or right justified per justify select
`timescale 1ns/10ps
`default_nettype none
module adj_top (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [adj_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [adj_pkg::DATA_W-1:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [adj_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [adj_pkg::DATA_W-1:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire adj_pkg::adj_conv_s conv,
   output logic conv_permit,
   input wire adj_pkg::adj_core_in_s core_in,
   output adj_pkg::adj_core_out_s core_out,
   output logic [adj_pkg::PAIR_W-1:0] result_pair,
   output logic irq
);
   logic aw_held_ff;
   logic [adj_pkg::ADDR_W-1:0] aw_addr_ff;
   logic w_held_ff;
   logic [adj_pkg::DATA_W-1:0] w_data_ff;
   logic [3:0] w_strb_ff;
   logic bvalid_ff;
   logic [1:0] bresp_ff;
   logic rvalid_ff;
   logic [adj_pkg::DATA_W-1:0] rdata_ff;
   logic [1:0] rresp_ff;
   logic flag_ff;
   logic enable_ff;
   logic [3:0] control_ff;
   logic [adj_pkg::RES_W-1:0] raw_ff;
   logic do_write;
   logic wr_lane0;
   logic clear_hit;
   logic conv_event;
   logic irq_int;
   logic asleep;
   logic wake;
   logic exec_next;
   logic vector;
   logic resume;
   logic [adj_pkg::PAIR_W-1:0] pair;

   // one register write through byte lane zero
   function automatic logic lane0_hit(input logic strobe, input logic [adj_pkg::ADDR_W-1:0] addr,
         input logic [adj_pkg::ADDR_W-1:0] ofs);
      return strobe && (addr == ofs);
   endfunction : lane0_hit

   // write address and data taken in either order
   assign s_axi_awready = !aw_held_ff;
   assign s_axi_wready = !w_held_ff;
   assign do_write = aw_held_ff && w_held_ff && !bvalid_ff;
   assign wr_lane0 = do_write && w_strb_ff[0];

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         aw_held_ff <= 1'b0;
         aw_addr_ff <= '0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_held_ff <= 1'b1;
         aw_addr_ff <= s_axi_awaddr;
      end else if (do_write) begin
         aw_held_ff <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         w_held_ff <= 1'b0;
         w_data_ff <= '0;
         w_strb_ff <= 4'h0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_held_ff <= 1'b1;
         w_data_ff <= s_axi_wdata;
         w_strb_ff <= s_axi_wstrb;
      end else if (do_write) begin
         w_held_ff <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         bvalid_ff <= 1'b0;
         bresp_ff <= adj_pkg::RESP_OKAY;
      end else if (do_write) begin
         bvalid_ff <= 1'b1;
         unique case (aw_addr_ff)
            adj_pkg::OFS_ENABLE, adj_pkg::OFS_CLEAR, adj_pkg::OFS_CONTROL: begin
               bresp_ff <= adj_pkg::RESP_OKAY;
            end
            default: begin
               bresp_ff <= adj_pkg::RESP_SLVERR;
            end
         endcase
      end else if (s_axi_bready) begin
         bvalid_ff <= 1'b0;
      end
   end

   assign s_axi_bvalid = bvalid_ff;
   assign s_axi_bresp = bresp_ff;

   // read port
   assign s_axi_arready = !rvalid_ff;

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         rvalid_ff <= 1'b0;
         rdata_ff <= '0;
         rresp_ff <= adj_pkg::RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         rvalid_ff <= 1'b1;
         rresp_ff <= adj_pkg::RESP_OKAY;
         unique case (s_axi_araddr)
            adj_pkg::OFS_STATUS: begin
               rdata_ff <= {31'h00000000, flag_ff};
            end
            adj_pkg::OFS_ENABLE: begin
               rdata_ff <= {31'h00000000, enable_ff};
            end
            adj_pkg::OFS_CLEAR: begin
               rdata_ff <= '0;
            end
            adj_pkg::OFS_CONTROL: begin
               rdata_ff <= {28'h0000000, control_ff};
            end
            adj_pkg::OFS_RESULT: begin
               rdata_ff <= {16'h0000, pair};
            end
            default: begin
               rdata_ff <= '0;
               rresp_ff <= adj_pkg::RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rready) begin
         rvalid_ff <= 1'b0;
      end
   end

   assign s_axi_rvalid = rvalid_ff;
   assign s_axi_rdata = rdata_ff;
   assign s_axi_rresp = rresp_ff;

   // control and enable registers
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         enable_ff <= adj_pkg::RST_ENABLE;
      end else if (lane0_hit(wr_lane0, aw_addr_ff, adj_pkg::OFS_ENABLE)) begin
         enable_ff <= w_data_ff[adj_pkg::BIT_DONE];
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         control_ff <= adj_pkg::RST_CONTROL;
      end else if (lane0_hit(wr_lane0, aw_addr_ff, adj_pkg::OFS_CONTROL)) begin
         control_ff <= w_data_ff[3:0];
      end
   end

   // conversion end accepted only when the engine may run
   assign conv_permit = !asleep || control_ff[adj_pkg::BIT_CLKSRC];
   assign conv_event = conv.done && conv_permit;

   // sticky done flag, set wins over clear
   assign clear_hit = lane0_hit(wr_lane0, aw_addr_ff, adj_pkg::OFS_CLEAR) && w_data_ff[adj_pkg::BIT_DONE];

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         flag_ff <= adj_pkg::RST_FLAG;
      end else if (conv_event) begin
         flag_ff <= 1'b1;
      end else if (clear_hit) begin
         flag_ff <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         raw_ff <= adj_pkg::RST_RESULT;
      end else if (conv_event) begin
         raw_ff <= conv.result;
      end
   end

   assign irq_int = flag_ff && enable_ff;
   assign irq = irq_int;

   adj_format u_format (
      .clk(clk),
      .rst_b(rst_b),
      .justify_left(control_ff[adj_pkg::BIT_JUSTIFY]),
      .raw(raw_ff),
      .pair(pair)
   );

   assign result_pair = pair;

   adj_wake u_wake (
      .clk(clk),
      .rst_b(rst_b),
      .irq(irq_int),
      .global_irq_enable(control_ff[adj_pkg::BIT_GLOBAL]),
      .peripheral_irq_enable(control_ff[adj_pkg::BIT_PERIPH]),
      .core_in(core_in),
      .asleep(asleep),
      .wake(wake),
      .exec_next(exec_next),
      .vector(vector),
      .resume(resume)
   );

   always_comb begin
      core_out.irq = irq_int;
      core_out.asleep = asleep;
      core_out.wake = wake;
      core_out.exec_next = exec_next;
      core_out.vector = vector;
      core_out.resume = resume;
   end

   flag_set_a: assert property (@(posedge clk) disable iff (!rst_b)
      conv_event |=> flag_ff)
      else $error("done flag not set after conversion");
   flag_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
      $fell(flag_ff) |-> $past(clear_hit) && !$past(conv_event))
      else $error("done flag dropped without clear");
   irq_gate_a: assert property (@(posedge clk) disable iff (!rst_b)
      core_out.irq == (flag_ff && enable_ff))
      else $error("core interrupt not gated by enable");
   sleep_block_a: assert property (@(posedge clk) disable iff (!rst_b)
      asleep && !control_ff[adj_pkg::BIT_CLKSRC] && conv.done && !flag_ff |=> !flag_ff)
      else $error("conversion accepted in sleep without rc clock");
   wake_irq_a: assert property (@(posedge clk) disable iff (!rst_b)
      asleep && irq_int |=> !asleep && exec_next)
      else $error("enabled interrupt did not wake");
   result_pick_a: assert property (@(posedge clk) disable iff (!rst_b)
      conv_event ##1 (!conv_event && $stable(control_ff)) ##1 $stable(control_ff) |->
         pair == (control_ff[adj_pkg::BIT_JUSTIFY] ? {raw_ff, 6'h00} : {6'h00, raw_ff}))
      else $error("result format wrong");
   flag_keep_a: assert property (@(posedge clk) disable iff (!rst_b)
      flag_ff && !clear_hit |=> flag_ff)
      else $error("done flag lost without clear");
   sleep_rc_conv_a: assert property (@(posedge clk) disable iff (!rst_b)
      asleep && control_ff[adj_pkg::BIT_CLKSRC] && conv.done |=> flag_ff)
      else $error("conversion refused in sleep with rc clock");
   run_irq_a: assert property (@(posedge clk) disable iff (!rst_b)
      !asleep && conv_event && enable_ff && !lane0_hit(wr_lane0, aw_addr_ff, adj_pkg::OFS_ENABLE) |=>
         core_out.irq)
      else $error("running conversion did not raise interrupt");

   // bus answers
   sequence write_pair_s;
      aw_held_ff && w_held_ff && !bvalid_ff;
   endsequence
   sequence read_taken_s;
      s_axi_arvalid && s_axi_arready;
   endsequence
   sequence result_read_s;
      s_axi_arvalid && s_axi_arready && (s_axi_araddr == adj_pkg::OFS_RESULT);
   endsequence

   write_once_a: assert property (@(posedge clk) disable iff (!rst_b)
      write_pair_s |=> bvalid_ff && !aw_held_ff && !w_held_ff)
      else $error("write not answered after address and data");
   read_answer_a: assert property (@(posedge clk) disable iff (!rst_b)
      read_taken_s |=> rvalid_ff)
      else $error("read not answered next cycle");
   bad_read_a: assert property (@(posedge clk) disable iff (!rst_b)
      s_axi_arvalid && s_axi_arready && (s_axi_araddr > adj_pkg::OFS_RESULT) |=> rresp_ff == adj_pkg::RESP_SLVERR)
      else $error("unmapped read not refused");
   result_read_a: assert property (@(posedge clk) disable iff (!rst_b)
      result_read_s |=> rdata_ff == {16'h0000, $past(pair)})
      else $error("result register differs from formatted pair");
endmodule : adj_top
`default_nettype wire

// [verif/adj_core_model.sv]
// file: core-side model answering the sleep and wake handshake
`timescale 1ns/10ps
`default_nettype none
module adj_core_model (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic go_sleep,
   input wire logic [3:0] lat,
   input wire adj_pkg::adj_core_out_s core_out,
   output var adj_pkg::adj_core_in_s core_in
);
   logic [3:0] cnt_ff;
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         core_in <= '0;
         cnt_ff <= 4'h0;
      end else begin
         core_in.sleep_enter <= go_sleep;
         core_in.instr_done <= 1'b0;
         // finish the instruction after sleep, promptly or slowly
         if (core_out.exec_next && !core_in.instr_done) begin
            cnt_ff <= cnt_ff + 4'h1;
            if (cnt_ff == lat) begin
               core_in.instr_done <= 1'b1;
               cnt_ff <= 4'h0;
            end
         end
      end
   end
endmodule : adj_core_model
`default_nettype wire

// [verif/adj_top_tb.sv]
// file: self-checking bench for the conversion-done interrupt block
`timescale 1ns/10ps
`default_nettype none
module adj_top_tb;
   localparam logic [7:0] ST = adj_pkg::OFS_STATUS;
   localparam logic [7:0] EN = adj_pkg::OFS_ENABLE;
   localparam logic [7:0] CL = adj_pkg::OFS_CLEAR;
   localparam logic [7:0] CT = adj_pkg::OFS_CONTROL;
   localparam logic [7:0] RS = adj_pkg::OFS_RESULT;
   localparam logic [1:0] OK = adj_pkg::RESP_OKAY;
   localparam logic [1:0] ER = adj_pkg::RESP_SLVERR;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic [7:0] awaddr = 8'h00;
   logic [7:0] araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'hF;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, conv_permit, irq;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic [15:0] pair;
   adj_pkg::adj_conv_s conv = '0;
   adj_pkg::adj_core_in_s core_in;
   adj_pkg::adj_core_out_s core_out;
   logic go_sleep = 1'b0;
   logic [3:0] lat = 4'h0;
   int fails = 0, num_checks = 0;
   int m_flag = 0, m_en = 0, m_ctl = 0, m_res = 0, m_sleep = 0;
   int g, i;
   always #2 clk = ~clk;
   adj_top dut (.clk(clk), .rst_b(rst_b), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .conv(conv),
      .conv_permit(conv_permit), .core_in(core_in), .core_out(core_out), .result_pair(pair), .irq(irq));
   adj_core_model core (.clk(clk), .rst_b(rst_b), .go_sleep(go_sleep), .lat(lat), .core_out(core_out),
      .core_in(core_in));
   task automatic stop_test;
      $display("checks %0d fails %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : stop_test
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic expire;
      fails++;
      stop_test();
   endtask : expire
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      int n;
      logic ha, hw, hb;
      logic [1:0] r;
      n = 0;
      hb = 1'b0;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!hb) begin
         @(negedge clk);
         ha = awvalid & awready;
         hw = wvalid & wready;
         hb = bvalid;
         r = bresp;
         @(posedge clk);
         if (ha) awvalid <= 1'b0;
         if (hw) wvalid <= 1'b0;
         n++;
         if (n > 50) expire();
      end
      bready <= 1'b0;
      @(posedge clk);
      chk(r, er);
   endtask : wr
   task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      int n;
      logic ha, hr;
      logic [31:0] d;
      logic [1:0] r;
      n = 0;
      hr = 1'b0;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (!hr) begin
         @(negedge clk);
         ha = arvalid & arready;
         hr = rvalid;
         d = rdata;
         r = rresp;
         @(posedge clk);
         if (ha) arvalid <= 1'b0;
         n++;
         if (n > 50) expire();
      end
      rready <= 1'b0;
      @(posedge clk);
      chk(r, er);
      if (er == OK) chk(d, e);
   endtask : rchk
   task automatic cnv(input logic [9:0] v);
      conv.done <= 1'b1;
      conv.result <= v;
      @(posedge clk);
      conv.done <= 1'b0;
      if (m_sleep == 0 || m_ctl[3]) begin
         m_flag = 1;
         m_res = v;
      end
   endtask : cnv
   task automatic see;
      @(negedge clk);
      chk(irq, m_flag & m_en);
      chk(core_out.irq, m_flag & m_en);
      chk(core_out.asleep, m_sleep);
      chk({core_out.wake, core_out.exec_next, core_out.vector, core_out.resume}, 4'h0);
      chk(conv_permit, !m_sleep || m_ctl[3]);
      chk(pair, m_ctl[0] ? m_res << 6 : m_res);
      @(posedge clk);
   endtask : see
   task automatic wake_watch(input logic [1:0] e);
      int n;
      logic x;
      logic [1:0] vr;
      logic w;
      n = 0;
      x = 1'b0;
      w = 1'b0;
      vr = 2'b00;
      while (vr == 2'b00) begin
         @(negedge clk);
         vr = {core_out.vector, core_out.resume};
         if (vr == 2'b00 && core_out.exec_next) x = 1'b1;
         if (core_out.wake) w = 1'b1;
         n++;
         if (n > 60) expire();
      end
      chk(x, 1'b1);
      chk(w, 1'b1);
      chk(vr, e);
      @(posedge clk);
   endtask : wake_watch
   initial begin
      void'($urandom(32'h7BFC));
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      rchk(ST, 0, OK);
      rchk(EN, 0, OK);
      rchk(CT, 0, OK);
      rchk(RS, 0, OK);
      rchk(8'h14, 0, ER);
      cnv(10'($urandom));
      repeat (2) @(posedge clk);
      see();
      rchk(ST, 1, OK);
      wr(ST, 0, ER);
      rchk(ST, 1, OK);
      wr(EN, 1, OK);
      m_en = 1;
      see();
      wstrb <= 4'h0;
      wr(CL, 1, OK);
      wstrb <= 4'hF;
      see();
      wr(CL, 1, OK);
      m_flag = 0;
      see();
      for (i = 0; i < 8; i++) begin
         m_ctl = i & 1;
         wr(CT, m_ctl, OK);
         cnv(10'($urandom));
         repeat (2) @(posedge clk);
         see();
         rchk(RS, m_ctl[0] ? m_res << 6 : m_res, OK);
         wr(CL, 1, OK);
         m_flag = 0;
      end
      for (g = 0; g < 4; g++) begin
         m_ctl = g << 1;
         wr(CT, m_ctl, OK);
         lat <= 4'($urandom % 4);
         go_sleep <= 1'b1;
         @(posedge clk);
         go_sleep <= 1'b0;
         repeat (3) @(posedge clk);
         m_sleep = 1;
         cnv(10'($urandom));
         repeat (2) @(posedge clk);
         see();
         m_ctl = m_ctl | 8;
         wr(CT, m_ctl, OK);
         see();
         cnv(10'($urandom));
         wake_watch(g == 3 ? 2'b10 : 2'b01);
         m_sleep = 0;
         see();
         wr(CL, 1, OK);
         m_flag = 0;
      end
      stop_test();
   end
endmodule : adj_top_tb
`default_nettype wire
